/* shared/fsp_consts.vh */
// Register map, command codes and timing for the flash self programmer
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH

// Register indices (printed offsets) and byte addresses
`define FSP_IDX_CMD          8'h94
`define FSP_IDX_ADDR_LO      8'h95
`define FSP_IDX_ADDR_HI      8'h96
`define FSP_IDX_BUF_PTR      8'h97
`define FSP_IDX_STATUS       8'h98
`define FSP_ADR_CMD          12'h250
`define FSP_ADR_ADDR_LO      12'h254
`define FSP_ADR_ADDR_HI      12'h258
`define FSP_ADR_BUF_PTR      12'h25C
`define FSP_ADR_STATUS       12'h260

// Reset values
`define FSP_RST_ADDR_LO      8'h00
`define FSP_RST_ADDR_HI      8'h00
`define FSP_RST_BUF_PTR      8'h00

// Command codes
`define FSP_CMD_PAGE         8'h5A
`define FSP_CMD_BYTE         8'h1E

// Array geometry
`define FSP_PAGE_BYTES       6'd32
`define FSP_OFS_BITS         5
`define FSP_PAGE_LSB         5
`define FSP_ADDR_MSB         12

// Status fields
`define FSP_ST_BUSY_BIT      0
`define FSP_ST_REJ_BIT       1

// Erase and program times in microseconds, and cycle counts at 125 MHz
`define FSP_CLK_MHZ          125
`define FSP_ERASE_US         3000
`define FSP_PROG_US          3000
`define FSP_ERASE_CYC        (`FSP_ERASE_US * `FSP_CLK_MHZ)
`define FSP_PROG_CYC         (`FSP_PROG_US * `FSP_CLK_MHZ)

`endif

/* src/fsp_timer.v */
// Down counter that times one erase or program phase
`timescale 1ns/1ps
`include "fsp_consts.vh"

module fsp_timer (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // Control
   input  wire        load_i,
   input  wire [23:0] count_i,
   // Status
   output reg         done_o
);

   reg [23:0] cnt_ff;
   reg        run_ff;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 24'h000000;
         run_ff <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (load_i) begin
            cnt_ff <= count_i;
            run_ff <= 1'b1;
         end else if (run_ff) begin
            if (cnt_ff <= 24'h000001) begin
               run_ff <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 24'h000001;
            end
         end
      end
   end

endmodule

/* src/fsp_top.v */
// Flash self programmer: APB registers, RAM fetch, erase and program
// Operation
// - Flash is 256 pages of 32 bytes
// - Page source is 32 consecutive RAM bytes
// - Buffer pointer: 8-bit RW, resets zero
// - Page mode uses address bits 12:5
// - Code 0x5A starts page operation
// - Code 0x1E starts byte operation
// - Byte mode uses address bits 12:0
// - Each operation erases then programs
`timescale 1ns/1ps
`include "fsp_consts.vh"

module fsp_top #(
   parameter ERASE_CYC = `FSP_ERASE_CYC,
   parameter PROG_CYC  = `FSP_PROG_CYC
) (
   // Clock and reset
   input  wire        SYS_CLK_I,
   input  wire        RST_N_I,
   // APB slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg  [31:0] PRDATA_O,
   output reg         PREADY_O,
   output reg         PSLVERR_O,
   // Internal RAM read port
   output reg         RAM_RD_O,
   output reg  [7:0]  RAM_ADDR_O,
   input  wire [7:0]  RAM_RDATA_I,
   // Flash array port
   output reg         FL_ERASE_O,
   output reg         FL_PROG_O,
   output reg         FL_PAGE_MODE_O,
   output reg  [12:0] FL_ADDR_O,
   output reg  [7:0]  FL_WDATA_O,
   output reg         FL_WE_O,
   // Processor fetch hold
   output reg         FETCH_HOLD_O
);

   localparam ST_IDLE  = 3'd0;
   localparam ST_FETCH = 3'd1;
   localparam ST_CATCH = 3'd2;
   localparam ST_ERASE = 3'd3;
   localparam ST_LOAD  = 3'd4;
   localparam ST_PROG  = 3'd5;

   reg  [7:0]  addr_lo_ff;
   reg  [7:0]  addr_hi_ff;
   reg  [7:0]  buf_ptr_ff;
   reg         reject_ff;
   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg         page_mode_ff;
   reg  [5:0]  idx_ff;
   reg  [5:0]  nxt_idx;
   reg  [7:0]  buf_mem [0:31];
   reg  [15:0] tgt_ff;
   reg         tmr_load;
   reg  [23:0] tmr_count;
   wire        tmr_done;
   wire        apb_acc;
   wire        apb_wr;
   wire        apb_rd;
   wire        busy;
   wire        start_page;
   wire        start_byte;
   wire [5:0]  op_len;
   reg  [31:0] rd_mux;
   reg         addr_ok;

   assign apb_acc = PSEL_I & PENABLE_I & ~PREADY_O;
   assign apb_wr  = apb_acc & PWRITE_I;
   assign apb_rd  = apb_acc & ~PWRITE_I;
   assign busy    = (state_ff != ST_IDLE);
   assign start_page = apb_wr & (PADDR_I == `FSP_ADR_CMD) & ~busy &
                       (PWDATA_I[7:0] == `FSP_CMD_PAGE);
   assign start_byte = apb_wr & (PADDR_I == `FSP_ADR_CMD) & ~busy &
                       (PWDATA_I[7:0] == `FSP_CMD_BYTE);
   assign op_len = page_mode_ff ? `FSP_PAGE_BYTES : 6'd1;

   // Address decode and read data
   always @* begin
      rd_mux  = 32'h00000000;
      addr_ok = 1'b1;
      case (PADDR_I)
         `FSP_ADR_CMD: rd_mux = 32'h00000000;
         `FSP_ADR_ADDR_LO: rd_mux = {24'h000000, addr_lo_ff};
         `FSP_ADR_ADDR_HI: rd_mux = {24'h000000, addr_hi_ff};
         `FSP_ADR_BUF_PTR: rd_mux = {24'h000000, buf_ptr_ff};
         `FSP_ADR_STATUS: begin
            rd_mux[`FSP_ST_BUSY_BIT] = busy;
            rd_mux[`FSP_ST_REJ_BIT]  = reject_ff;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // APB answer one cycle into the access phase
   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h00000000;
      end else begin
         PREADY_O  <= apb_acc;
         PSLVERR_O <= apb_acc & ~addr_ok;
         if (apb_rd) begin
            PRDATA_O <= rd_mux;
         end
      end
   end

   // Setup registers, frozen while an operation runs
   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         addr_lo_ff <= `FSP_RST_ADDR_LO;
         addr_hi_ff <= `FSP_RST_ADDR_HI;
         buf_ptr_ff <= `FSP_RST_BUF_PTR;
         reject_ff  <= 1'b0;
      end else if (apb_wr & ~busy) begin
         if (PADDR_I == `FSP_ADR_ADDR_LO) begin
            addr_lo_ff <= PWDATA_I[7:0];
         end
         if (PADDR_I == `FSP_ADR_ADDR_HI) begin
            addr_hi_ff <= PWDATA_I[7:0];
         end
         if (PADDR_I == `FSP_ADR_BUF_PTR) begin
            buf_ptr_ff <= PWDATA_I[7:0];
         end
         if (PADDR_I == `FSP_ADR_CMD) begin
            reject_ff <= ~(start_page | start_byte);
         end
      end
   end

   // Sequencer next state
   always @* begin
      nxt_state = state_ff;
      nxt_idx   = idx_ff;
      tmr_load  = 1'b0;
      tmr_count = 24'h000000;
      case (state_ff)
         ST_IDLE: begin
            if (start_page | start_byte) begin
               nxt_state = ST_FETCH;
               nxt_idx   = 6'd0;
            end
         end
         ST_FETCH: nxt_state = ST_CATCH;
         ST_CATCH: begin
            if (idx_ff + 6'd1 >= op_len) begin
               nxt_state = ST_ERASE;
               tmr_load  = 1'b1;
               tmr_count = ERASE_CYC[23:0] - 24'h000001;
               nxt_idx   = 6'd0;
            end else begin
               nxt_state = ST_FETCH;
               nxt_idx   = idx_ff + 6'd1;
            end
         end
         ST_ERASE: begin
            if (tmr_done) begin
               nxt_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (idx_ff + 6'd1 >= op_len) begin
               nxt_state = ST_PROG;
               tmr_load  = 1'b1;
               tmr_count = PROG_CYC[23:0] - 24'h000001;
            end else begin
               nxt_idx = idx_ff + 6'd1;
            end
         end
         ST_PROG: begin
            if (tmr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Sequencer state and target capture
   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_ff     <= ST_IDLE;
         idx_ff       <= 6'd0;
         page_mode_ff <= 1'b0;
         tgt_ff       <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         idx_ff   <= nxt_idx;
         if (start_page | start_byte) begin
            page_mode_ff <= start_page;
            if (start_page) begin
               tgt_ff <= {addr_hi_ff, addr_lo_ff[7:5], 5'h00};
            end else begin
               tgt_ff <= {addr_hi_ff, addr_lo_ff};
            end
         end
      end
   end

   // RAM fetch into local buffer
   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RAM_RD_O   <= 1'b0;
         RAM_ADDR_O <= 8'h00;
      end else begin
         RAM_RD_O <= (nxt_state == ST_FETCH);
         RAM_ADDR_O <= buf_ptr_ff + {2'b00, nxt_idx};
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_buf
         always @(posedge SYS_CLK_I) begin
            if (state_ff == ST_CATCH && idx_ff[4:0] == gi) begin
               buf_mem[gi] <= RAM_RDATA_I;
            end
         end
      end
   endgenerate

   // Flash array drive
   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FL_ERASE_O     <= 1'b0;
         FL_PROG_O      <= 1'b0;
         FL_PAGE_MODE_O <= 1'b0;
         FL_ADDR_O      <= 13'h0000;
         FL_WDATA_O     <= 8'h00;
         FL_WE_O        <= 1'b0;
         FETCH_HOLD_O   <= 1'b0;
      end else begin
         FL_ERASE_O     <= (nxt_state == ST_ERASE);
         FL_PROG_O      <= (nxt_state == ST_PROG);
         FL_PAGE_MODE_O <= page_mode_ff;
         FL_WE_O        <= (nxt_state == ST_LOAD);
         // page number above five offset bits
         FL_ADDR_O <= {tgt_ff[`FSP_ADDR_MSB:`FSP_PAGE_LSB],
                       tgt_ff[4:0] | nxt_idx[4:0]};
         FL_WDATA_O <= buf_mem[nxt_idx[4:0]];
         FETCH_HOLD_O <= (nxt_state != ST_IDLE);
      end
   end

   fsp_timer u_timer (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .load_i  (tmr_load),
      .count_i (tmr_count),
      .done_o  (tmr_done)
   );

endmodule

/* tb/fsp_chk_props.sv */
// Port checks for the flash self programmer
`timescale 1ns/1ps
`include "fsp_consts.vh"
module fsp_chk #(
   parameter ERASE_CYC = 8,
   parameter PROG_CYC  = 8
) (
   // Clock and reset
   input logic        SYS_CLK_I,
   input logic        RST_N_I,
   // APB
   input logic        PSEL_I,
   input logic        PENABLE_I,
   input logic        PWRITE_I,
   input logic [11:0] PADDR_I,
   input logic [31:0] PWDATA_I,
   input logic [31:0] PRDATA_O,
   input logic        PREADY_O,
   input logic        PSLVERR_O,
   // RAM, flash and hold
   input logic        RAM_RD_O,
   input logic        FL_ERASE_O,
   input logic        FL_PROG_O,
   input logic        FL_PAGE_MODE_O,
   input logic [12:0] FL_ADDR_O,
   input logic        FL_WE_O,
   input logic        FETCH_HOLD_O
);
   reg  [23:0] e_cnt_ff;
   reg  [23:0] p_cnt_ff;
   reg  [5:0]  w_cnt_ff;
   wire        good_w;
   assign good_w = PWDATA_I[7:0] == `FSP_CMD_PAGE ||
                   PWDATA_I[7:0] == `FSP_CMD_BYTE;
   // Phase lengths and latch loads per operation
   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         e_cnt_ff <= 24'h0;
         p_cnt_ff <= 24'h0;
         w_cnt_ff <= 6'h0;
      end else begin
         e_cnt_ff <= FL_ERASE_O ? e_cnt_ff + 24'h1 : 24'h0;
         p_cnt_ff <= FL_PROG_O ? p_cnt_ff + 24'h1 : 24'h0;
         w_cnt_ff <= FETCH_HOLD_O ? w_cnt_ff + {5'h0, FL_WE_O} : 6'h0;
      end
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_cmd;
      PSEL_I && PENABLE_I && !PREADY_O && PWRITE_I && !FETCH_HOLD_O &&
      PADDR_I == `FSP_ADR_CMD;
   endsequence
   chk_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O
      |=> PREADY_O) else $error("ready not after one wait");
   chk_err_pair: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   chk_start_hold: assert property (
      s_cmd ##0 good_w |-> ##[1:3] FETCH_HOLD_O)
      else $error("start code did not start");
   chk_bad_idle: assert property (
      s_cmd ##0 !good_w |=> !FETCH_HOLD_O [*4])
      else $error("reserved code started");
   chk_erase_len: assert property (
      !FL_ERASE_O && e_cnt_ff != 0 |-> e_cnt_ff == ERASE_CYC)
      else $error("erase length wrong");
   chk_prog_len: assert property (
      !FL_PROG_O && p_cnt_ff != 0 |-> p_cnt_ff == PROG_CYC)
      else $error("program length wrong");
   chk_phase_hold: assert property (
      FL_ERASE_O || FL_PROG_O || FL_WE_O || RAM_RD_O
      |-> FETCH_HOLD_O && !(FL_ERASE_O && FL_PROG_O))
      else $error("phase outside hold");
   chk_page_addr: assert property (
      FL_WE_O && FL_PAGE_MODE_O |-> FL_ADDR_O[4:0] == w_cnt_ff[4:0])
      else $error("page byte address wrong");
   chk_we_count: assert property (
      $rose(FL_PROG_O) |-> w_cnt_ff == (FL_PAGE_MODE_O ? 6'h20 : 6'h01))
      else $error("latch load count wrong");
   chk_erase_first: assert property (
      $rose(FL_ERASE_O) |-> w_cnt_ff == 6'h0)
      else $error("load before erase");
endmodule

/* tb/fsp_top_test.sv */
// Self-checking bench for the flash self programmer
`timescale 1ns/1ps
`include "fsp_consts.vh"
module fsp_top_test;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic        err;
   } fsp_row_t;
   localparam ERASE_CYC = 8;
   localparam PROG_CYC  = 8;
   reg        SYS_CLK_I = 1'h0, RST_N_I = 1'h0;
   reg        PSEL_I = 1'h0, PENABLE_I = 1'h0, PWRITE_I = 1'h0;
   reg [11:0] PADDR_I = 12'h0;
   reg [31:0] PWDATA_I = 32'h0;
   reg [7:0]  RAM_RDATA_I = 8'h0;
   wire [31:0] PRDATA_O;
   wire        PREADY_O, PSLVERR_O, RAM_RD_O, FL_ERASE_O, FL_PROG_O;
   wire        FL_PAGE_MODE_O, FL_WE_O, FETCH_HOLD_O;
   wire [7:0]  RAM_ADDR_O, FL_WDATA_O;
   wire [12:0] FL_ADDR_O;
   reg [7:0]  mem [0:255];
   reg [7:0]  fl [0:8191];
   reg [31:0] rd;
   reg        er;
   int        err_total = 0, cmp_count = 0, we_n = 0, we_base = 0;
   fsp_row_t  rows [4] = '{
      '{`FSP_ADR_ADDR_LO, 32'hA5, 32'hA5, 1'h0},
      '{`FSP_ADR_ADDR_HI, 32'hFFFFFF3C, 32'h3C, 1'h0},
      '{`FSP_ADR_BUF_PTR, 32'h7E, 32'h7E, 1'h0},
      '{12'h300, 32'h55, 32'h0, 1'h1}};
   fsp_top #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) i_dut (.*);
   initial forever #4 SYS_CLK_I = ~SYS_CLK_I;
   // RAM with one cycle latency, flash latch capture
   always @(posedge SYS_CLK_I) begin
      RAM_RDATA_I <= RAM_RD_O ? mem[RAM_ADDR_O] : ~RAM_RDATA_I;
      if (FL_WE_O) begin
         fl[FL_ADDR_O] <= FL_WDATA_O;
         we_n <= we_n + 1;
      end
   end
   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string n, input [31:0] e, input [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s exp %h got %h", n, e, g);
         err_total++;
      end
   endtask
   task apb(input bit w, input [11:0] a, input [31:0] d);
      int n;
      @(posedge SYS_CLK_I);
      PSEL_I <= 1'h1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge SYS_CLK_I);
      PENABLE_I <= 1'h1;
      n = 0;
      do begin
         @(posedge SYS_CLK_I);
         n++;
      end while (PREADY_O !== 1'h1 && n < 20);
      if (PREADY_O !== 1'h1) begin
         err_total++;
         stop_test;
      end
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 1'h0;
      PENABLE_I <= 1'h0;
   endtask
   task rd_chk(input [11:0] a, input [31:0] e, input string n);
      apb(0, a, 32'h0);
      chk(n, e, rd);
   endtask
   task wait_idle;
      int k;
      k = 0;
      do begin
         apb(0, `FSP_ADR_STATUS, 32'h0);
         k++;
      end while (rd[0] !== 1'h0 && k < 100);
      if (rd[0] !== 1'h0) begin
         err_total++;
         stop_test;
      end
   endtask
   task run(input [7:0] c, input [7:0] hi, input [7:0] lo, input [7:0] p);
      apb(1, `FSP_ADR_ADDR_HI, {24'h0, hi});
      apb(1, `FSP_ADR_ADDR_LO, {24'h0, lo});
      apb(1, `FSP_ADR_BUF_PTR, {24'h0, p});
      we_base = we_n;
      apb(1, `FSP_ADR_CMD, {24'h0, c});
      repeat (2) @(posedge SYS_CLK_I);
   endtask
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i * 7 + 3);
      repeat (10) @(posedge SYS_CLK_I);
      RST_N_I <= 1'h1;
      rd_chk(`FSP_ADR_BUF_PTR, 32'h0, "ptr reset");
      rd_chk(`FSP_ADR_ADDR_LO, 32'h0, "lo reset");
      rd_chk(`FSP_ADR_ADDR_HI, 32'h0, "hi reset");
      foreach (rows[i]) begin
         apb(1, rows[i].a, rows[i].d);
         chk("wr err", rows[i].err, er);
         apb(0, rows[i].a, 32'h0);
         chk("rd err", rows[i].err, er);
         if (!rows[i].err)
            chk("rd data", rows[i].e, rd);
      end
      apb(1, `FSP_ADR_CMD, 32'h33);
      rd_chk(`FSP_ADR_STATUS, 32'h2, "reject");
      chk("no start", 32'h0, FETCH_HOLD_O);
      rd_chk(`FSP_ADR_CMD, 32'h0, "cmd reads zero");
      run(`FSP_CMD_PAGE, 8'h1F, 8'hC7, 8'h60);
      apb(1, `FSP_ADR_BUF_PTR, 32'h11);
      chk("hold", 32'h1, FETCH_HOLD_O);
      rd_chk(`FSP_ADR_BUF_PTR, 32'h60, "busy ptr");
      wait_idle;
      chk("page loads", 32'd32, we_n - we_base);
      for (int i = 0; i < 32; i++)
         chk("page", mem[8'h60 + i], fl[13'h1FC0 + i]);
      run(`FSP_CMD_BYTE, 8'h01, 8'h05, 8'hFF);
      wait_idle;
      chk("status", 32'h0, rd);
      chk("byte loads", 32'd1, we_n - we_base);
      chk("byte", mem[255], fl[13'h0105]);
      run(`FSP_CMD_PAGE, 8'h00, 8'h40, 8'h10);
      repeat (20) @(posedge SYS_CLK_I);
      RST_N_I <= 1'h0;
      @(posedge SYS_CLK_I);
      RST_N_I <= 1'h1;
      chk("hold reset", 32'h0, FETCH_HOLD_O);
      rd_chk(`FSP_ADR_BUF_PTR, 32'h0, "ptr reset");
      stop_test;
   end
endmodule
bind fsp_top fsp_chk #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) u_chk (.*);
